// ### mcuxs_core.sv
// Decided for this implementation: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "mcuxs_regs.svh"
// Behaviour
// [RULE1] Timer configuration register reachable by ordinary file instructions.
// [RULE2] Software should avoid the dedicated configuration-load instruction.
// [RULE3] Return from irq pops stack into program counter, flags unchanged.
// [RULE4] Return from irq sets master enable bit 7 in Q3.
// [RULE5] Return from irq: pop in Q4, second cycle is a no-op.
// [RULE6] Return with literal loads accumulator and pops in Q4, then no-op.
// [RULE7] Sleep clears powerdown flag and sets expiry flag.
// [RULE8] Sleep clears watchdog counter and prescaler, single cycle.
// [RULE9] Sleep stops the oscillator in Q4.
// [RULE10] Rotate left through carry; only carry flag changes.
// [RULE11] Destination bit zero writes accumulator, one writes file register.
// [RULE12] Call pushes following address onto the stack.
// [RULE13] Rotate right through carry; old carry into bit 7.
// [RULE14] Increment, store by destination, skip next when zero.
module mcuxs_core #(
  parameter int FILES = 128,
  parameter int STACK_DEPTH = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Status
  output logic sleeping
);
  mcuxs_pkg::mcuxs_phase_e phase_r;
  mcuxs_pkg::mcuxs_dec_s dec;
  logic [13:0] instr_r;
  logic run_r, nopCycle_r, busy_r;
  logic [12:0] pc_r, stackTop;
  logic [7:0] acc_r, tcfg_r, ictl_r, stat_r, wdog_r, pres_r, fData, result;
  logic [7:0] file_r [FILES];
  logic [6:0] fSel_r;
  logic apbWr, apbRd, stPush, stPop, q4, exec, resNew;

  // Instruction decode, shared by the execute stage
  function automatic mcuxs_pkg::mcuxs_dec_s decode(input logic [13:0] i);
    mcuxs_pkg::mcuxs_dec_s d;
    d.op = mcuxs_pkg::MCUXS_I_NOP;
    d.dest = i[7];
    d.fAddr = i[6:0];
    d.lit = i[10:0];
    if (i == `MCUXS_OP_RETIRQ)
      d.op = mcuxs_pkg::MCUXS_I_RETIRQ;
    else if (i == `MCUXS_OP_LDCFG)
      d.op = mcuxs_pkg::MCUXS_I_LDCFG;
    else if (i == `MCUXS_OP_SLEEP)
      d.op = mcuxs_pkg::MCUXS_I_SLEEP;
    else if (i[13:11] == `MCUXS_OP_CALL)
      d.op = mcuxs_pkg::MCUXS_I_CALL;
    else if (i[13:10] == `MCUXS_OP_RETLIT)
      d.op = mcuxs_pkg::MCUXS_I_RETLIT;
    else if (i[13:8] == `MCUXS_OP_RLC)
      d.op = mcuxs_pkg::MCUXS_I_RLC;
    else if (i[13:8] == `MCUXS_OP_RRC)
      d.op = mcuxs_pkg::MCUXS_I_RRC;
    else if (i[13:8] == `MCUXS_OP_INCSZ)
      d.op = mcuxs_pkg::MCUXS_I_INCSZ;
    else if (i[13:7] == `MCUXS_OP_MOVWF)
      d.op = mcuxs_pkg::MCUXS_I_MOVWF;
    return d;
  endfunction

  // File read, special registers mapped into file space
  function automatic logic [7:0] fileRead(input logic [6:0] a,
    input logic [7:0] mem, input logic [7:0] t, input logic [7:0] s,
    input logic [7:0] ic);
    unique case (a)
      `MCUXS_FA_TCFG: fileRead = t; // [RULE1]
      `MCUXS_FA_STAT: fileRead = s;
      `MCUXS_FA_ICTL: fileRead = ic;
      default: fileRead = mem;
    endcase
  endfunction

  assign dec = decode(instr_r);
  assign q4 = phase_r == mcuxs_pkg::MCUXS_Q4;
  assign exec = busy_r && !nopCycle_r;
  assign fData = fileRead(dec.fAddr, file_r[dec.fAddr], tcfg_r, stat_r,
    ictl_r);
  assign apbWr = psel && penable && pwrite;
  assign apbRd = psel && !penable && !pwrite;

  // Datapath result for file-operand instructions
  always_comb
  begin
    result = fData;
    unique case (dec.op)
      mcuxs_pkg::MCUXS_I_RLC:
        result = {fData[6:0], stat_r[`MCUXS_CARRY_BIT]}; // [RULE10]
      mcuxs_pkg::MCUXS_I_RRC:
        result = {stat_r[`MCUXS_CARRY_BIT], fData[7:1]}; // [RULE13]
      mcuxs_pkg::MCUXS_I_INCSZ:
        result = fData + 8'h01; // [RULE14]
      mcuxs_pkg::MCUXS_I_MOVWF:
        result = acc_r;
      default:
        result = fData;
    endcase
  end
  assign resNew = dec.op inside {mcuxs_pkg::MCUXS_I_RLC,
    mcuxs_pkg::MCUXS_I_RRC, mcuxs_pkg::MCUXS_I_INCSZ,
    mcuxs_pkg::MCUXS_I_MOVWF};

  // Stack push on call, pop on returns in Q4
  assign stPush = exec && q4 && dec.op == mcuxs_pkg::MCUXS_I_CALL; // [RULE12]
  assign stPop = exec && q4 && (dec.op == mcuxs_pkg::MCUXS_I_RETIRQ ||
    dec.op == mcuxs_pkg::MCUXS_I_RETLIT); // [RULE3] [RULE5] [RULE6]

  mcuxs_stack #(.DEPTH(STACK_DEPTH), .AW(13)) uStack (
    .clk(clk),
    .sys_rst(sys_rst),
    .push(stPush),
    .pushData(pc_r + 13'h0001),
    .pop(stPop),
    .stackTop(stackTop)
  );

  // Quarter-cycle sequencer
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      phase_r <= mcuxs_pkg::MCUXS_Q1;
    else if (!busy_r)
      phase_r <= mcuxs_pkg::MCUXS_Q1;
    else
      unique case (phase_r)
        mcuxs_pkg::MCUXS_Q1: phase_r <= mcuxs_pkg::MCUXS_Q2;
        mcuxs_pkg::MCUXS_Q2: phase_r <= mcuxs_pkg::MCUXS_Q3;
        mcuxs_pkg::MCUXS_Q3: phase_r <= mcuxs_pkg::MCUXS_Q4;
        mcuxs_pkg::MCUXS_Q4: phase_r <= mcuxs_pkg::MCUXS_Q1;
      endcase
  end

  // Instruction issue and two-cycle tracking
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      busy_r <= 1'b0;
      nopCycle_r <= 1'b0;
      instr_r <= '0;
    end
    else if (!busy_r && apbWr && paddr == `MCUXS_CTRL_OFF && !run_r)
    begin
      busy_r <= 1'b1;
      nopCycle_r <= 1'b0;
      instr_r <= pwdata[13:0];
    end
    else if (busy_r && q4)
    begin
      if (!nopCycle_r && (dec.op == mcuxs_pkg::MCUXS_I_RETIRQ ||
          dec.op == mcuxs_pkg::MCUXS_I_RETLIT ||
          dec.op == mcuxs_pkg::MCUXS_I_CALL ||
          (dec.op == mcuxs_pkg::MCUXS_I_INCSZ && result == 8'h00)))
        nopCycle_r <= 1'b1; // [RULE5] [RULE6] [RULE14]
      else
        busy_r <= 1'b0;
    end
  end

  // Program counter
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      pc_r <= `MCUXS_PC_RST;
    else if (stPop)
      pc_r <= stackTop; // [RULE3] [RULE6]
    else if (stPush)
      pc_r <= {pc_r[12:11], dec.lit};
    else if (busy_r && q4 && (!nopCycle_r ||
        dec.op == mcuxs_pkg::MCUXS_I_INCSZ))
      pc_r <= pc_r + 13'h0001; // [RULE5] [RULE14] Branch no-op keeps target
    else if (apbWr && paddr == `MCUXS_PC_OFF && !busy_r)
      pc_r <= pwdata[12:0];
  end

  // Accumulator
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      acc_r <= '0;
    else if (exec && q4 && dec.op == mcuxs_pkg::MCUXS_I_RETLIT)
      acc_r <= dec.lit[7:0]; // [RULE6]
    else if (exec && q4 && resNew && !dec.dest &&
        dec.op != mcuxs_pkg::MCUXS_I_MOVWF)
      acc_r <= result; // [RULE11]
    else if (apbWr && paddr == `MCUXS_ACC_OFF && !busy_r)
      acc_r <= pwdata[7:0];
  end

  // Timer configuration register
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      tcfg_r <= `MCUXS_TCFG_RST;
    else if (exec && q4 && dec.op == mcuxs_pkg::MCUXS_I_LDCFG)
      tcfg_r <= acc_r;
    else if (exec && q4 && resNew && dec.dest &&
        dec.fAddr == `MCUXS_FA_TCFG)
      tcfg_r <= result; // [RULE1] [RULE11]
    else if (apbWr && paddr == `MCUXS_TCFG_OFF && !busy_r)
      tcfg_r <= pwdata[7:0];
  end

  // General file memory
  always_ff @(posedge clk)
  begin
    if (exec && q4 && resNew && dec.dest)
      file_r[dec.fAddr] <= result; // [RULE11]
    else if (apbWr && paddr == `MCUXS_FILE_OFF && !busy_r)
      file_r[fSel_r] <= pwdata[7:0];
  end

  // File window pointer from pwdata bits 14:8 of any WDOG register write
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      fSel_r <= '0;
    else if (apbWr && paddr == `MCUXS_CTRL_OFF && busy_r)
      fSel_r <= fSel_r;
    else if (apbWr && paddr == `MCUXS_WDOG_OFF)
      fSel_r <= pwdata[14:8];
  end

  // Interrupt control
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      ictl_r <= '0;
    else if (exec && phase_r == mcuxs_pkg::MCUXS_Q3 &&
        dec.op == mcuxs_pkg::MCUXS_I_RETIRQ)
      ictl_r[`MCUXS_IRQEN_BIT] <= 1'b1; // [RULE4]
    else if (exec && q4 && resNew && dec.dest &&
        dec.fAddr == `MCUXS_FA_ICTL)
      ictl_r <= result;
    else if (apbWr && paddr == `MCUXS_ICTL_OFF && !busy_r)
      ictl_r <= pwdata[7:0];
  end

  // Status flags, watchdog and sleep
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      stat_r <= `MCUXS_STAT_RST;
      wdog_r <= '0;
      pres_r <= '0;
      run_r <= 1'b0;
    end
    else if (exec && q4 && dec.op == mcuxs_pkg::MCUXS_I_SLEEP)
    begin
      stat_r[`MCUXS_PWRDN_BIT] <= 1'b0; // [RULE7]
      stat_r[`MCUXS_EXPIRY_BIT] <= 1'b1; // [RULE7]
      wdog_r <= 8'h00; // [RULE8]
      pres_r <= 8'h00; // [RULE8]
      run_r <= 1'b1; // [RULE9]
    end
    else if (exec && q4 && (dec.op == mcuxs_pkg::MCUXS_I_RLC ||
        dec.op == mcuxs_pkg::MCUXS_I_RRC))
      stat_r[`MCUXS_CARRY_BIT] <= dec.op == mcuxs_pkg::MCUXS_I_RLC ?
        fData[7] : fData[0]; // [RULE10] [RULE13]
    else if (apbWr && paddr == `MCUXS_STAT_OFF)
    begin
      if (pwdata[`MCUXS_SLEEP_BIT])
        run_r <= 1'b0;
      stat_r[`MCUXS_CARRY_BIT] <= pwdata[`MCUXS_CARRY_BIT];
    end
    else if (!run_r)
    begin
      pres_r <= pres_r + 8'h01;
      if (pres_r == 8'hff)
        wdog_r <= wdog_r + 8'h01;
    end
  end

  // APB read data and answer
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      sleeping <= 1'b0;
    end
    else
    begin
      sleeping <= run_r;
      pready <= psel && !penable;
      pslverr <= psel && !penable && paddr > `MCUXS_WDOG_OFF;
      if (apbRd)
        unique case (paddr)
          `MCUXS_CTRL_OFF: prdata <= {18'h0, instr_r};
          `MCUXS_STAT_OFF: prdata <= {27'h0, busy_r, run_r,
            stat_r[`MCUXS_EXPIRY_BIT], stat_r[`MCUXS_PWRDN_BIT],
            stat_r[`MCUXS_CARRY_BIT]};
          `MCUXS_ACC_OFF: prdata <= {24'h0, acc_r};
          `MCUXS_PC_OFF: prdata <= {19'h0, pc_r};
          `MCUXS_TCFG_OFF: prdata <= {24'h0, tcfg_r};
          `MCUXS_ICTL_OFF: prdata <= {24'h0, ictl_r};
          `MCUXS_FILE_OFF: prdata <= {24'h0, file_r[fSel_r]};
          `MCUXS_WDOG_OFF: prdata <= {9'h0, fSel_r, wdog_r, pres_r};
          default: prdata <= '0;
        endcase
    end
  end
endmodule // mcuxs_core

// ### mcuxs_core_assertions.sv
`timescale 1ns/1ps
module mcuxs_core_assertions (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Status
  input wire logic sleeping
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Finished transfer and wake request
  wire logic wakeHit = psel && penable && pready && pwrite &&
    paddr == 12'h004 && pwdata[3];
  // Transfer steps
  sequence sDone;
    psel && penable && pready;
  endsequence
  sequence sSleepCmd;
    sDone ##0 pwrite && paddr == 12'h000 && pwdata[13:0] == 14'h0063;
  endsequence
  AST_READY_NEXT: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  AST_READY_QUAL: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  AST_ERR_UNMAPPED: assert property (sDone ##0 paddr > 12'h01c
    |-> pslverr && prdata == 32'h0) else $error("unmapped not refused");
  AST_ERR_MAPPED: assert property (sDone ##0 paddr <= 12'h01c |-> !pslverr)
    else $error("mapped access refused");
  AST_READ_UPPER: assert property (sDone ##0 !pwrite && paddr < 12'h01c
    |-> prdata[31:16] == 16'h0) else $error("upper read bits set");
  AST_SLEEP_ENTER: assert property (sSleepCmd |-> ##[1:8] sleeping)
    else $error("sleep not entered");
  AST_SLEEP_HOLD: assert property (sleeping && !wakeHit && !$past(wakeHit)
    |=> sleeping) else $error("sleep left without wake");
  AST_WAKE: assert property (sleeping && wakeHit |-> ##[1:4] !sleeping)
    else $error("wake ignored");
endmodule // mcuxs_core_assertions
bind mcuxs_core mcuxs_core_assertions i_chk (.clk(clk), .sys_rst(sys_rst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .sleeping(sleeping));

// ### mcuxs_pkg.sv
package mcuxs_pkg;
  // Quarter-cycle phase, Gray coded
  typedef enum logic [1:0] {
    MCUXS_Q1 = 2'b00,
    MCUXS_Q2 = 2'b01,
    MCUXS_Q3 = 2'b11,
    MCUXS_Q4 = 2'b10
  } mcuxs_phase_e;
  // Decoded instruction class
  typedef enum logic [3:0] {
    MCUXS_I_NOP, MCUXS_I_RETIRQ, MCUXS_I_RETLIT, MCUXS_I_LDCFG,
    MCUXS_I_SLEEP, MCUXS_I_RLC, MCUXS_I_RRC, MCUXS_I_INCSZ,
    MCUXS_I_CALL, MCUXS_I_MOVWF
  } mcuxs_op_e;
  // Decoded instruction
  typedef struct packed {
    mcuxs_op_e op;
    logic dest;
    logic [6:0] fAddr;
    logic [10:0] lit;
  } mcuxs_dec_s;
endpackage

// ### mcuxs_regs.svh
`ifndef MCUXS_REGS_SVH
`define MCUXS_REGS_SVH
// APB register byte offsets
`define MCUXS_CTRL_OFF 12'h000
`define MCUXS_STAT_OFF 12'h004
`define MCUXS_ACC_OFF 12'h008
`define MCUXS_PC_OFF 12'h00c
`define MCUXS_TCFG_OFF 12'h010
`define MCUXS_ICTL_OFF 12'h014
`define MCUXS_FILE_OFF 12'h018
`define MCUXS_WDOG_OFF 12'h01c
// Field positions
`define MCUXS_IRQEN_BIT 7
`define MCUXS_CARRY_BIT 0
`define MCUXS_PWRDN_BIT 1
`define MCUXS_EXPIRY_BIT 2
`define MCUXS_SLEEP_BIT 3
`define MCUXS_BUSY_BIT 4
// Reset values
`define MCUXS_PC_RST 13'h0000
`define MCUXS_STAT_RST 8'h06
`define MCUXS_TCFG_RST 8'hff
// Opcodes (14 bit)
`define MCUXS_OP_RETIRQ 14'h0009
`define MCUXS_OP_LDCFG 14'h0062
`define MCUXS_OP_SLEEP 14'h0063
`define MCUXS_OP_CALL 3'h4
`define MCUXS_OP_RETLIT 4'hd
`define MCUXS_OP_RLC 6'h0d
`define MCUXS_OP_RRC 6'h0c
`define MCUXS_OP_INCSZ 6'h0f
`define MCUXS_OP_MOVWF 7'h01
// Special file addresses reachable by register instructions
`define MCUXS_FA_TCFG 7'h01
`define MCUXS_FA_STAT 7'h03
`define MCUXS_FA_ICTL 7'h0b
`endif

// ### mcuxs_stack.sv
`timescale 1ns/1ps
module mcuxs_stack #(
  parameter int DEPTH = 8,
  parameter int AW = 13
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Push and pop
  input wire logic push,
  input wire logic [AW-1:0] pushData,
  input wire logic pop,
  output logic [AW-1:0] stackTop
);
  localparam int PW = $clog2(DEPTH);
  logic [AW-1:0] mem [DEPTH];
  logic [PW-1:0] ptr_r;

  // Circular stack pointer, wraps on overflow
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      ptr_r <= '0;
    else if (push)
      ptr_r <= ptr_r + 1'b1;
    else if (pop)
      ptr_r <= ptr_r - 1'b1;
  end

  // Storage
  always_ff @(posedge clk)
  begin
    if (push)
      mem[ptr_r] <= pushData;
  end

  assign stackTop = mem[ptr_r - 1'b1];
endmodule // mcuxs_stack

// ### tb_top.sv
`timescale 1ns/1ps
`define CHK(g, e) begin nCompared++; if ((g) !== (e)) begin errCount++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top;
  localparam logic [11:0] STA = 12'h004, ACC = 12'h008, PCR = 12'h00c;
  localparam logic [11:0] TCF = 12'h010, ICT = 12'h014, FIL = 12'h018;
  localparam logic [11:0] WDG = 12'h01c;
  logic clk, sysRst, psel, penable, pwrite, pready, pslverr, sleeping;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic lastErr;
  logic [12:0] pc0;
  int errCount = 0, nCompared = 0, n1, n2, p;
  logic [13:0] rOp[4] = '{14'h0d20, 14'h0da0, 14'h0ca0, 14'h0c20};
  logic [31:0] aExp[4] = '{32'h2d, 32'h2d, 32'h2d, 32'hcb};
  logic [31:0] fExp[4] = '{32'h96, 32'h2d, 32'h96, 32'h96};
  logic [31:0] sExp[4] = '{32'h07, 32'h07, 32'h07, 32'h06};
  // Design under test
  mcuxs_core i_dut (.clk(clk), .sys_rst(sysRst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sleeping(sleeping));
  // Clock
  initial
  begin
    clk = 0;
    forever #10 clk = ~clk;
  end
  // One APB transfer, held until ready
  task automatic xfer(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do
    begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) errCount++;
    // Answer taken at the same rising edge that sees pready high
    rd = prdata;
    lastErr = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  // Read and compare
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    xfer(0, a, 32'h0);
    `CHK(rd, e)
  endtask
  // Run one opcode, count busy polls
  task automatic exec(input logic [13:0] op, output int polls);
    xfer(1, 12'h000, {18'h0, op});
    polls = 0;
    do
    begin
      xfer(0, STA, 32'h0);
      polls++;
    end while (rd[4] !== 1'b0 && polls < 40);
  endtask
  // Verdict
  task results;
    $display("compared %0d mismatches %0d", nCompared, errCount);
    if (errCount == 0 && nCompared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Watchdog
  initial
  begin
    repeat (20000) @(posedge clk);
    errCount++;
    results();
  end
  // Tests
  initial
  begin
    psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; sysRst = 1;
    repeat (5) @(posedge clk);
    sysRst <= 0;
    rdc(STA, 32'h06);
    rdc(TCF, 32'hff);
    rdc(ICT, 32'h0);
    rdc(12'h020, 32'h0);
    `CHK(lastErr, 1'b1)
    $display("test reset done");
    xfer(1, ACC, 32'h5a);
    exec(14'h0081, p);
    rdc(TCF, 32'h5a);
    xfer(1, WDG, 32'h0100);
    rdc(FIL, 32'h5a);
    xfer(1, ACC, 32'h33);
    exec(14'h0062, p);
    rdc(TCF, 32'h33);
    $display("test config done");
    xfer(1, WDG, 32'h2000);
    xfer(1, FIL, 32'h96);
    xfer(1, STA, 32'h01);
    for (int i = 0; i < 4; i++)
    begin
      exec(rOp[i], n1);
      rdc(ACC, aExp[i]);
      rdc(FIL, fExp[i]);
      rdc(STA, sExp[i]);
    end
    $display("test rotate done");
    xfer(1, STA, 32'h01);
    xfer(0, PCR, 32'h0);
    pc0 = rd[12:0];
    exec(14'h2123, p);
    rdc(PCR, 32'h123);
    exec(14'h0009, n2);
    rdc(PCR, {19'h0, pc0 + 13'h1});
    rdc(ICT, 32'h80);
    rdc(STA, 32'h07);
    `CHK(n2 > n1, 1'b1)
    xfer(0, PCR, 32'h0);
    pc0 = rd[12:0];
    exec(14'h2040, p);
    exec(14'h34a5, n2);
    rdc(ACC, 32'ha5);
    rdc(PCR, {19'h0, pc0 + 13'h1});
    `CHK(n2 > n1, 1'b1)
    $display("test return done");
    xfer(1, STA, 32'h00);
    xfer(1, FIL, 32'hff);
    xfer(0, PCR, 32'h0);
    pc0 = rd[12:0];
    exec(14'h0fa0, p);
    rdc(FIL, 32'h0);
    rdc(PCR, {19'h0, pc0 + 13'h2});
    xfer(1, FIL, 32'h05);
    xfer(0, PCR, 32'h0);
    pc0 = rd[12:0];
    exec(14'h0f20, p);
    rdc(ACC, 32'h06);
    rdc(FIL, 32'h05);
    rdc(PCR, {19'h0, pc0 + 13'h1});
    $display("test skip done");
    exec(14'h0063, p);
    rdc(STA, 32'h0c);
    xfer(0, WDG, 32'h0);
    `CHK(rd[15:0], 16'h0)
    @(negedge clk);
    `CHK(sleeping, 1'b1)
    xfer(1, STA, 32'h08);
    xfer(0, ACC, 32'h0);
    @(negedge clk);
    `CHK(sleeping, 1'b0)
    $display("test sleep done");
    results();
  end
endmodule // tb_top
